// ---- logic/ddrpc_pkg.sv ----
// Purpose: Shared constants for the bank precharge and auto-precharge timing block.
// Assumes: Four banks, one command clock at 250 MHz, Wishbone register access.
// Notes: Register offsets are byte addresses of 32-bit words.
package ddrpc_pkg;
  localparam int unsigned DDRPC_NBANK = 4;
  localparam int unsigned DDRPC_CLK_PS = 4000;
  // Analog times in picoseconds.
  localparam int unsigned DDRPC_TRTP_PS = 7500;
  localparam int unsigned DDRPC_TRP_PS = 15000;
  localparam int unsigned DDRPC_TRAS_PS = 45000;
  // Cycle counts, rounded up as least times.
  localparam int unsigned DDRPC_RTP_CYC = (DDRPC_TRTP_PS + DDRPC_CLK_PS - 1) / DDRPC_CLK_PS;
  localparam int unsigned DDRPC_RP_CYC = (DDRPC_TRP_PS + DDRPC_CLK_PS - 1) / DDRPC_CLK_PS;
  localparam int unsigned DDRPC_RAS_CYC = (DDRPC_TRAS_PS + DDRPC_CLK_PS - 1) / DDRPC_CLK_PS;
  localparam int unsigned DDRPC_CW = 8;
  // Least gap after the last prefetch before an internal precharge.
  localparam logic [7:0] DDRPC_PREF_GAP = 8'h02;
  localparam logic [7:0] DDRPC_BL8_PREF = 8'h02;
  // Command encodings on {ras_n, cas_n, we_n} with cs_n low.
  localparam logic [2:0] DDRPC_CMD_ACT = 3'h3;
  localparam logic [2:0] DDRPC_CMD_PRE = 3'h2;
  localparam logic [2:0] DDRPC_CMD_WR = 3'h4;
  localparam logic [2:0] DDRPC_CMD_RD = 3'h5;
  // Register map.
  localparam logic [3:0] DDRPC_REG_CFG = 4'h0;
  localparam logic [3:0] DDRPC_REG_STAT = 4'h4;
  localparam logic [3:0] DDRPC_REG_CNT = 4'h8;
  // Configuration fields: AL, CL, WR, burst length 8 flag.
  localparam int unsigned DDRPC_CFG_AL_LSB = 0;
  localparam int unsigned DDRPC_CFG_CL_LSB = 4;
  localparam int unsigned DDRPC_CFG_WR_LSB = 8;
  localparam int unsigned DDRPC_CFG_BL8_BIT = 12;
  localparam logic [31:0] DDRPC_CFG_RST = 32'h0000_0330;
  typedef enum logic [1:0] {
    DDRPC_B_IDLE = 2'b00,
    DDRPC_B_ACTIVE = 2'b01,
    DDRPC_B_APWAIT = 2'b10,
    DDRPC_B_PRECH = 2'b11
  } ddrpc_bank_e;
endpackage : ddrpc_pkg

// ---- logic/ddrpc_bank.sv ----
// Purpose: One bank's open, auto-precharge and precharge state.
// Assumes: Commands are decoded by the parent and arrive as one-cycle pulses.
// Notes: The row active counter saturates at its maximum; the down counters hold at zero.
`timescale 1ns/100ps
`default_nettype none
module ddrpc_bank
  import ddrpc_pkg::*;
#(
  parameter int unsigned CW = DDRPC_CW
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Decoded commands for this bank.
  input wire logic act_i,
  input wire logic pre_i,
  input wire logic ap_rd_i,
  input wire logic ap_wr_i,
  // Configured latencies in cycles.
  input wire logic [CW-1:0] rd_sched_i,
  input wire logic [CW-1:0] rtp_gate_i,
  input wire logic [CW-1:0] wr_sched_i,
  // State.
  output logic open_o,
  output logic prech_o,
  output logic ap_start_o
);
  ddrpc_bank_e st_r, st_nxt;
  logic [CW-1:0] ras_r, ras_nxt;
  logic [CW-1:0] ap_r, ap_nxt;
  logic [CW-1:0] gate_r, gate_nxt;
  logic [CW-1:0] rp_r, rp_nxt;
  logic start_r, start_nxt;
  logic ras_ok;

  // Row active time measured from the last activate.
  assign ras_ok = (ras_r >= CW'(DDRPC_RAS_CYC));

  // Next state of the bank.
  always_comb
  begin
    st_nxt = st_r;
    ras_nxt = (ras_r == {CW{1'b1}}) ? ras_r : ras_r + 1'b1;
    ap_nxt = (ap_r == '0) ? ap_r : ap_r - 1'b1;
    gate_nxt = (gate_r == '0) ? gate_r : gate_r - 1'b1;
    rp_nxt = (rp_r == '0) ? rp_r : rp_r - 1'b1;
    start_nxt = 1'b0;
    if (pre_i)
    begin
      st_nxt = DDRPC_B_PRECH; // Latest precharge restarts the period.
      rp_nxt = CW'(DDRPC_RP_CYC);
    end
    else if (act_i)
    begin
      st_nxt = DDRPC_B_ACTIVE;
      ras_nxt = '0;
    end
    else if (ap_rd_i)
    begin
      st_nxt = DDRPC_B_APWAIT;
      ap_nxt = rd_sched_i; // Scheduled at AL plus BL/2.
      gate_nxt = rtp_gate_i; // Read to precharge floor.
    end
    else if (ap_wr_i)
    begin
      st_nxt = DDRPC_B_APWAIT;
      ap_nxt = wr_sched_i; // After burst end plus write recovery.
      gate_nxt = '0;
    end
    else
    begin
      case (st_r)
        DDRPC_B_APWAIT:
        begin
          // Start only once schedule, row active and read to precharge are met.
          if (ap_r <= CW'(1) && gate_r <= CW'(1) && ras_ok)
          begin
            st_nxt = DDRPC_B_PRECH;
            rp_nxt = CW'(DDRPC_RP_CYC);
            start_nxt = 1'b1;
          end
        end
        DDRPC_B_PRECH:
        begin
          if (rp_r <= CW'(1))
          begin
            st_nxt = DDRPC_B_IDLE;
          end
        end
        default:
        begin
          st_nxt = st_r; // Plain reads and writes leave the bank open.
        end
      endcase
    end
  end

  // Bank state registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= DDRPC_B_IDLE;
      ras_r <= '0;
      ap_r <= '0;
      gate_r <= '0;
      rp_r <= '0;
      start_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      ras_r <= ras_nxt;
      ap_r <= ap_nxt;
      gate_r <= gate_nxt;
      rp_r <= rp_nxt;
      start_r <= start_nxt;
    end
  end

  assign open_o = (st_r == DDRPC_B_ACTIVE) || (st_r == DDRPC_B_APWAIT);
  assign prech_o = (st_r == DDRPC_B_PRECH);
  assign ap_start_o = start_r;
endmodule : ddrpc_bank
`default_nettype wire

// ---- logic/ddrpc_top.sv ----
// Purpose: Bank close logic of a four-bank DDR2 device on its command pins.
// Assumes: Command pins come from another clock domain and are synchronised.
// Notes: Timing that binds the controller is listed but not enforced here.
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ddrpc_top
  import ddrpc_pkg::*;
#(
  parameter int unsigned NBANK = DDRPC_NBANK
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Command pins from the controller.
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic a10_i,
  input wire logic [1:0] ba_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Bank state.
  output logic [NBANK-1:0] bank_open_o,
  output logic [NBANK-1:0] bank_prech_o
);
  logic [6:0] pin_s1_r, pin_s2_r;
  logic [31:0] cfg_r, cfg_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [15:0] apcnt_r, apcnt_nxt;
  logic [NBANK-1:0] open_r, prech_r;
  logic [NBANK-1:0] open_w, prech_w, start_w;
  logic [NBANK-1:0] act_w, pre_w, aprd_w, apwr_w;
  logic [2:0] cmd_w;
  logic cmd_v, s_a10;
  logic [1:0] s_ba;
  logic [DDRPC_CW-1:0] al_w, cl_w, wr_w, half_w, rd_sched, rtp_gate, wr_sched, wl_w;

  // Two-stage synchroniser on the command pins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_r <= 7'h7F;
      pin_s2_r <= 7'h7F;
    end
    else
    begin
      pin_s1_r <= {cs_n_i, ras_n_i, cas_n_i, we_n_i, a10_i, ba_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign cmd_v = ~pin_s2_r[6];
  assign cmd_w = pin_s2_r[5:3];
  assign s_a10 = pin_s2_r[2];
  assign s_ba = pin_s2_r[1:0];

  // Latency fields and derived schedules.
  assign al_w = DDRPC_CW'(cfg_r[DDRPC_CFG_AL_LSB +: 4]);
  assign cl_w = DDRPC_CW'(cfg_r[DDRPC_CFG_CL_LSB +: 4]);
  assign wr_w = DDRPC_CW'(cfg_r[DDRPC_CFG_WR_LSB +: 4]);
  assign half_w = cfg_r[DDRPC_CFG_BL8_BIT] ? DDRPC_CW'(4) : DDRPC_CW'(2);
  assign wl_w = al_w + cl_w - DDRPC_CW'(1);
  assign rd_sched = al_w + half_w;
  // Last prefetch at AL, or AL+2 for BL8; gate is that plus max(RTP, 2).
  assign rtp_gate = al_w + (cfg_r[DDRPC_CFG_BL8_BIT] ? DDRPC_BL8_PREF : 8'h00)
    + ((DDRPC_RTP_CYC > 2) ? DDRPC_CW'(DDRPC_RTP_CYC) : DDRPC_PREF_GAP);
  assign wr_sched = wl_w + half_w + wr_w;

  // Per-bank command decode.
  genvar gi;
  generate
    for (gi = 0; gi < NBANK; gi++)
    begin : g_bank
      logic sel;
      assign sel = (s_ba == 2'(gi));
      assign act_w[gi] = cmd_v && cmd_w == DDRPC_CMD_ACT && sel;
      assign pre_w[gi] = cmd_v && cmd_w == DDRPC_CMD_PRE && (s_a10 || sel);
      assign aprd_w[gi] = cmd_v && cmd_w == DDRPC_CMD_RD && s_a10 && sel;
      assign apwr_w[gi] = cmd_v && cmd_w == DDRPC_CMD_WR && s_a10 && sel;
      ddrpc_bank #(.CW(DDRPC_CW)) u_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .act_i(act_w[gi]),
        .pre_i(pre_w[gi]),
        .ap_rd_i(aprd_w[gi]),
        .ap_wr_i(apwr_w[gi]),
        .rd_sched_i(rd_sched),
        .rtp_gate_i(rtp_gate),
        .wr_sched_i(wr_sched),
        .open_o(open_w[gi]),
        .prech_o(prech_w[gi]),
        .ap_start_o(start_w[gi])
      );
    end
  endgenerate

  // Wishbone register access and auto-precharge start counter.
  always_comb
  begin
    cfg_nxt = cfg_r;
    dat_nxt = dat_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    apcnt_nxt = apcnt_r + 16'(|start_w);
    if (wb_cyc_i && wb_stb_i && !ack_r && !err_r)
    begin
      dat_nxt = 32'h0000_0000;
      if (wb_adr_i == DDRPC_REG_CFG)
      begin
        ack_nxt = 1'b1;
        dat_nxt = cfg_r;
        if (wb_we_i)
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (wb_sel_i[i])
            begin
              cfg_nxt[i*8 +: 8] = wb_dat_i[i*8 +: 8];
            end
          end
        end
      end
      else if (wb_adr_i == DDRPC_REG_STAT)
      begin
        ack_nxt = 1'b1;
        dat_nxt = {24'h00_0000, prech_r, open_r};
      end
      else if (wb_adr_i == DDRPC_REG_CNT)
      begin
        ack_nxt = 1'b1;
        dat_nxt = {16'h0000, apcnt_r};
        if (wb_we_i)
        begin
          apcnt_nxt = 16'(|start_w); // A start in the clearing cycle still counts.
        end
      end
      else
      begin
        err_nxt = 1'b1;
      end
    end
  end

  // Register updates.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_r <= DDRPC_CFG_RST;
      dat_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      apcnt_r <= 16'h0000;
      open_r <= '0;
      prech_r <= '0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      apcnt_r <= apcnt_nxt;
      open_r <= open_w;
      prech_r <= prech_w;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign bank_open_o = open_r;
  assign bank_prech_o = prech_r;
endmodule : ddrpc_top
`default_nettype wire

// ---- tb/ddrpc_top_chk.sv ----
// Purpose: Checks bank state and bus answers at the top ports.
// Assumes: Commands come with legal controller spacing.
// Notes: A pin command shows on the bank outputs four edges later.
`timescale 1ns/100ps
`default_nettype none
module ddrpc_top_chk
  import ddrpc_pkg::*;
#(
  parameter int unsigned NBANK = DDRPC_NBANK
)
(
  // Watched ports.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic a10_i,
  input wire logic [1:0] ba_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [NBANK-1:0] bank_open_o,
  input wire logic [NBANK-1:0] bank_prech_o
);
  logic [2:0] cmd;
  logic act;
  logic pre;
  logic rd;
  logic wr;
  logic ap0;
  // Decodes the pins; a deselect reads as no command.
  assign cmd = cs_n_i ? 3'h7 : {ras_n_i, cas_n_i, we_n_i};
  assign act = cmd == DDRPC_CMD_ACT;
  assign pre = cmd == DDRPC_CMD_PRE;
  assign rd = cmd == DDRPC_CMD_RD;
  assign wr = cmd == DDRPC_CMD_WR;
  assign ap0 = a10_i && ba_i == 2'h0;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_act_open: assert property ($past(act, 4) |-> bank_open_o[$past(ba_i, 4)])
    else $error("bank not opened");
  a_pre_one: assert property ($past(pre && !a10_i, 4) |->
    bank_prech_o[$past(ba_i, 4)] && !bank_open_o[$past(ba_i, 4)])
    else $error("bank not closed");
  a_pre_all: assert property ($past(pre && a10_i, 4) |-> &bank_prech_o && !(|bank_open_o))
    else $error("not all banks closed");
  a_prech_len: assert property ($rose(bank_prech_o[0]) |-> bank_prech_o[0] [*4])
    else $error("precharge too short");
  a_rd_open: assert property (rd && !a10_i && ba_i == 2'h0 && bank_open_o[0] |=>
    bank_open_o[0] [*6])
    else $error("plain read closed bank");
  a_rd_ap: assert property (rd && ap0 |=> !bank_prech_o[0] [*5] ##[1:25] bank_prech_o[0])
    else $error("read precharge mistimed");
  a_wr_ap: assert property (wr && ap0 |=> !bank_prech_o[0] [*8] ##[1:30] bank_prech_o[0])
    else $error("write precharge mistimed");
  a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
    wb_ack_o || wb_err_o)
    else $error("bus not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
endmodule : ddrpc_top_chk
`default_nettype wire

// ---- tb/ddrpc_ctl_model.sv ----
// Purpose: Controller side putting bank commands on the pins.
// Assumes: The bench spaces its requests legally.
// Notes: Idle address lines show the inverse of their last value.
`timescale 1ns/100ps
`default_nettype none
module ddrpc_ctl_model
(
  // Clock and requests.
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] op_i,
  input wire logic a10_i,
  input wire logic [1:0] ba_i,
  // Command pins.
  output var logic cs_n_o,
  output var logic ras_n_o,
  output var logic cas_n_o,
  output var logic we_n_o,
  output var logic a10_o,
  output var logic [1:0] ba_o
);
  // Starts deselected so no pin is unknown.
  initial
  begin
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o} = 3'h7;
    a10_o = 1'b0;
    ba_o = 2'h0;
  end
  // One command per requested cycle, else a deselect.
  always @(posedge clk_i)
  begin
    cs_n_o <= !go_i;
    {ras_n_o, cas_n_o, we_n_o} <= go_i ? op_i : 3'h7;
    a10_o <= go_i ? a10_i : !a10_o;
    ba_o <= go_i ? ba_i : ~ba_o;
  end
endmodule : ddrpc_ctl_model
`default_nettype wire

// ---- tb/ddrpc_top_tb.sv ----
// Purpose: Self-checking bench for the bank close block.
// Assumes: Default timing values of the package.
// Notes: Register rows first, then command cases.
`timescale 1ns/100ps
`default_nettype none
module ddrpc_top_tb
  import ddrpc_pkg::*;
;
  typedef struct packed {
    logic we;
    logic [3:0] adr;
    logic [31:0] wd;
    logic [31:0] exp;
    logic err;
  } ddrpc_row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic [2:0] op = 3'h7;
  logic a10 = 1'b0;
  logic [1:0] ba = 2'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic cs_n_i;
  logic ras_n_i;
  logic cas_n_i;
  logic we_n_i;
  logic a10_i;
  logic [1:0] ba_i;
  logic [3:0] bank_open_o;
  logic [3:0] bank_prech_o;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int num_checks = 0;
  ddrpc_row_s rows [7] = '{
    '{1'b0, DDRPC_REG_CFG, 32'h0, DDRPC_CFG_RST, 1'b0},
    '{1'b0, DDRPC_REG_STAT, 32'h0, 32'h0, 1'b0},
    '{1'b0, DDRPC_REG_CNT, 32'h0, 32'h0, 1'b0},
    '{1'b0, 4'hC, 32'h0, 32'h0, 1'b1},
    '{1'b1, DDRPC_REG_CFG, 32'h0000_1331, 32'h0, 1'b0},
    '{1'b0, DDRPC_REG_CFG, 32'h0, 32'h0000_1331, 1'b0},
    '{1'b1, DDRPC_REG_CFG, DDRPC_CFG_RST, 32'h0, 1'b0}};
  // Clock of 4 ns.
  always #2 clk_i = ~clk_i;
  ddrpc_ctl_model u_ctl (.clk_i, .go_i(go), .op_i(op), .a10_i(a10), .ba_i(ba),
    .cs_n_o(cs_n_i), .ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i),
    .a10_o(a10_i), .ba_o(ba_i));
  ddrpc_top DUT (.clk_i, .rst_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .a10_i, .ba_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .bank_open_o, .bank_prech_o);
  // Compares and counts.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // Classic cycle held until ack or err.
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    // A bus that never answers counts as a mismatch.
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
      n_errors++;
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // Returns at the edge that samples the command when fin is set.
  task automatic cmd(input logic [2:0] o, input logic a, input logic [1:0] b, input logic fin);
    @(posedge clk_i);
    go <= 1'b1;
    op <= o;
    a10 <= a;
    ba <= b;
    if (fin)
    begin
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
    end
  endtask : cmd
  // Opens bank 0, closes it by auto-precharge, times the start.
  task automatic ap(input logic [2:0] o, input int gap, input int lo);
    int n;
    cmd(DDRPC_CMD_ACT, 1'b0, 2'h0, 1'b1);
    step(gap);
    cmd(o, 1'b1, 2'h0, 1'b1);
    n = 0;
    do
    begin
      step(1);
      n++;
    end
    while (bank_prech_o[0] !== 1'b1 && n < 60);
    chk(32'(n >= lo && n <= lo + 1), 32'h1);
    step(8);
  endtask : ap
  task automatic note(input int k);
    $display("test %0d done", k);
  endtask : note
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Main sequence.
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'({bank_open_o, bank_prech_o, wb_ack_o, wb_err_o}), 32'h0);
    foreach (rows[i])
    begin
      wb(rows[i].we, rows[i].adr, rows[i].wd);
      if (!rows[i].we)
        chk(rd, rows[i].exp);
      chk({31'h0, er}, {31'h0, rows[i].err});
    end
    note(1);
    for (int b = 0; b < 4; b++)
    begin
      cmd(DDRPC_CMD_ACT, 1'b0, 2'(b), 1'b1);
      step(4);
      chk(32'(bank_open_o), 32'((1 << (b + 1)) - 1));
    end
    step(DDRPC_RAS_CYC);
    cmd(DDRPC_CMD_PRE, 1'b0, 2'h1, 1'b1);
    step(4);
    chk(32'({bank_open_o, bank_prech_o}), 32'h0000_00D2);
    cmd(DDRPC_CMD_PRE, 1'b1, 2'h0, 1'b1);
    step(4);
    chk(32'({bank_open_o, bank_prech_o}), 32'h0000_000F);
    step(4);
    chk(32'(bank_prech_o), 32'h0);
    note(2);
    cmd(DDRPC_CMD_PRE, 1'b0, 2'h0, 1'b0);
    cmd(DDRPC_CMD_PRE, 1'b1, 2'h3, 1'b1);
    step(6);
    chk(32'(bank_prech_o), 32'h0000_000F);
    step(1);
    chk(32'(bank_prech_o), 32'h0);
    note(3);
    cmd(DDRPC_CMD_ACT, 1'b0, 2'h0, 1'b1);
    step(DDRPC_RAS_CYC);
    cmd(DDRPC_CMD_RD, 1'b0, 2'h0, 1'b1);
    step(10);
    chk(32'({bank_open_o[0], bank_prech_o[0]}), 32'h2);
    cmd(DDRPC_CMD_PRE, 1'b0, 2'h0, 1'b1);
    step(8);
    note(4);
    ap(DDRPC_CMD_RD, 0, DDRPC_RAS_CYC + 1);
    ap(DDRPC_CMD_RD, 16, 3 + 2);
    ap(DDRPC_CMD_WR, 16, 3 + 2 + 2 + 3);
    wb(1'b1, DDRPC_REG_CFG, 32'h0000_1331);
    ap(DDRPC_CMD_RD, 16, 3 + 1 + 4);
    ap(DDRPC_CMD_WR, 16, 3 + 3 + 4 + 3);
    wb(1'b0, DDRPC_REG_CNT, 32'h0);
    chk(rd, 32'h5);
    wb(1'b1, DDRPC_REG_CNT, 32'h0);
    wb(1'b0, DDRPC_REG_CNT, 32'h0);
    chk(rd, 32'h0);
    note(5);
    summarize();
  end
  // Watchdog at 5000 cycles, well past the few hundred cycles the cases take.
  initial
  begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule : ddrpc_top_tb
bind ddrpc_top ddrpc_top_chk #(.NBANK(NBANK)) u_chk (.clk_i, .rst_i, .cs_n_i, .ras_n_i,
  .cas_n_i, .we_n_i, .a10_i, .ba_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
  .bank_open_o, .bank_prech_o);
`default_nettype wire
